// ==== core/lpm_pkg.sv ====
// constants for the low-power wait/stop controller
// assumes a single 200 MHz reference clock and an active-low async reset
package lpm_pkg;

  // reference clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  // default oscillator stabilisation length in reference clock cycles
  localparam int unsigned OSC_WAIT_CYCLES = 4064;
  // power-on reset value of the delay select bit
  localparam logic        WAIT_SEL_RST    = 1'b1;
  // reset values of the condition flag inhibit bits
  localparam logic        MASK_I_RST      = 1'b1;
  localparam logic        MASK_X_RST      = 1'b1;
  // number of pwm channels and the counter width for the delay
  localparam int unsigned PWM_CHANNELS    = 4;
  localparam int unsigned DLY_W           = 16;
  localparam logic [DLY_W-1:0] DLY_ZERO   = 16'h0000;
  localparam logic [DLY_W-1:0] DLY_ONE    = 16'h0001;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_STACK,
    ST_IDLE,
    ST_STOP,
    ST_OSC_WAIT,
    ST_SERVICE
  } lpm_state_t;

endpackage : lpm_pkg

// ==== core/osc_delay.sv ====
// down-counter that times the oscillator stabilisation delay
// assumes the start pulse arrives while the counter is idle
`timescale 1ns/10ps
module osc_delay
  import lpm_pkg::*;
#(
  parameter logic [DLY_W-1:0] CYCLES = DLY_W'(OSC_WAIT_CYCLES)
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);

  logic [DLY_W-1:0] cnt_q;
  logic [DLY_W-1:0] cnt_d;
  logic             done_d;

  // ==========================================================
  // counter
  // load on start, count down, pulse done in the cycle after the last count
  assign cnt_d  = i_start ? CYCLES :
                  (cnt_q != DLY_ZERO) ? cnt_q - DLY_ONE : cnt_q;
  assign done_d = (cnt_q == DLY_ONE);
  assign o_busy = (cnt_q != DLY_ZERO);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q  <= DLY_ZERO;
      o_done <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      o_done <= done_d;
    end
  end

endmodule : osc_delay

// ==== core/lpm_ctrl.sv ====
// low-power wait/stop controller: idle opcode, stop instruction, clock gates
// assumes cpu decode strobes are one-cycle pulses synchronous to I_REF_CLK
`timescale 1ns/10ps
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int unsigned OSC_WAIT = OSC_WAIT_CYCLES,
  parameter int unsigned NPWM     = PWM_CHANNELS,
  parameter int unsigned AW       = 16
) (
  input  wire logic            I_REF_CLK,
  input  wire logic            I_NRST,
  // cpu side
  input  wire logic            i_idle_opcode,
  input  wire logic            i_stop_opcode,
  input  wire logic            i_stack_done,
  input  wire logic [AW-1:0]   i_flags_addr,
  input  wire logic            i_flag_i,
  input  wire logic            i_flag_x,
  input  wire logic            i_flag_s,
  input  wire logic            i_int_pending,
  input  wire logic            i_edge_irq_pending,
  input  wire logic            i_irq_n,
  input  wire logic            i_nmi_n,
  input  wire logic            i_warm_reset,
  // configuration bits
  input  wire logic            i_watchdog_off,
  input  wire logic            i_timer2_halt_ctrl,
  input  wire logic            i_timer3_halt_ctrl,
  input  wire logic            i_spi_on,
  input  wire logic            i_serial_tx_on,
  input  wire logic            i_serial_rx_on,
  input  wire logic [NPWM-1:0] i_pwm_channel_on,
  input  wire logic            i_converter_power_on,
  input  wire logic            i_wait_sel_wr,
  input  wire logic            i_wait_sel_val,
  // outputs
  output logic                 o_stack_req,
  output logic                 o_bus_rd,
  output logic [AW-1:0]        o_bus_addr,
  output logic                 o_cpu_clk_en,
  output logic                 o_osc_en,
  output logic                 o_timer1_clk_en,
  output logic                 o_timer2_clk_en,
  output logic                 o_timer3_clk_en,
  output logic                 o_spi_clk_en,
  output logic                 o_serial_tx_clk_en,
  output logic                 o_serial_rx_clk_en,
  output logic [NPWM-1:0]      o_pwm_clk_en,
  output logic                 o_converter_pwr,
  output logic                 o_set_mask_i,
  output logic                 o_set_mask_x,
  output logic                 o_service_nmi,
  output logic                 o_resume,
  output logic                 o_oscillator_wait_select,
  output logic [2:0]           o_state
);

  // ==========================================================
  // state and wake decode
  lpm_state_t state_q;
  lpm_state_t state_d;
  logic       wait_sel_q;
  logic       nmi_wake_q;
  logic       nmi_wake_d;
  logic       dly_start;
  logic       dly_busy;
  logic       dly_done;
  logic       por_q;

  // maskable line only counts when its mask is clear
  wire irq_wake  = !i_irq_n && !i_flag_i;
  // nmi line wakes regardless of its mask
  wire nmi_wake  = !i_nmi_n;
  wire stop_wake = irq_wake || nmi_wake ||
                   (i_edge_irq_pending && !i_flag_i);
  wire in_idle   = (state_q == ST_IDLE);
  wire in_stop   = (state_q == ST_STOP);
  // stop taken only with the halt disable flag clear
  wire stop_ok   = i_stop_opcode && !i_flag_s;

  // the delay is also run once after power-on (por_q set at reset)
  osc_delay #(
    .CYCLES (DLY_W'(OSC_WAIT))
  ) u_dly (
    .i_clk   (I_REF_CLK),
    .i_nrst  (I_NRST),
    .i_start (dly_start),
    .o_busy  (dly_busy),
    .o_done  (dly_done)
  );

  // ==========================================================
  // next state
  always_comb begin
    state_d    = state_q;
    nmi_wake_d = nmi_wake_q;
    dly_start  = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (por_q) begin
          // power-on always waits for the oscillator
          state_d   = ST_OSC_WAIT;
          dly_start = 1'b1;
        end else if (i_idle_opcode) begin
          state_d = ST_STACK;
        end else if (stop_ok) begin
          state_d = ST_STOP;
        end
      end
      ST_STACK: begin
        if (i_stack_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (i_int_pending) begin
          state_d = ST_SERVICE;
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          nmi_wake_d = nmi_wake && !i_flag_x;
          if (wait_sel_q) begin
            state_d   = ST_OSC_WAIT;
            dly_start = 1'b1;
          end else begin
            state_d = (nmi_wake && i_flag_x) ? ST_RUN : ST_SERVICE;
          end
        end
      end
      ST_OSC_WAIT: begin
        if (dly_done) begin
          // after stop: nmi with mask set just continues
          if (nmi_wake_q || irq_wake || i_edge_irq_pending) begin
            state_d = ST_SERVICE;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_SERVICE: begin
        state_d    = ST_RUN;
        nmi_wake_d = 1'b0;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ==========================================================
  // state registers; warm reset skips the delay
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q    <= ST_RUN;
      nmi_wake_q <= 1'b0;
      por_q      <= 1'b1;
    end else begin
      state_q    <= i_warm_reset ? ST_RUN : state_d;
      nmi_wake_q <= i_warm_reset ? 1'b0 : nmi_wake_d;
      por_q      <= 1'b0;
    end
  end

  // delay select: set by any reset, cleared by software
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wait_sel_q <= WAIT_SEL_RST;
    end else if (i_warm_reset) begin
      wait_sel_q <= WAIT_SEL_RST;
    end else if (i_wait_sel_wr) begin
      wait_sel_q <= i_wait_sel_val;
    end
  end

  // ==========================================================
  // gate decode
  wire stopped   = (state_d == ST_STOP) || (state_d == ST_OSC_WAIT);
  wire idling    = (state_d == ST_IDLE);
  // in idle the main timer halts only with mask set and watchdog off
  wire t1_halt   = idling && i_flag_i && i_watchdog_off;
  wire t2_halt   = idling && i_timer2_halt_ctrl;
  wire t3_halt   = idling && i_timer3_halt_ctrl;
  wire entering  = (state_q != ST_SERVICE) && (state_d == ST_SERVICE);

  // ==========================================================
  // registered outputs
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      o_stack_req              <= 1'b0;
      o_bus_rd                 <= 1'b0;
      o_bus_addr               <= '0;
      o_cpu_clk_en             <= 1'b0;
      o_osc_en                 <= 1'b1;
      o_timer1_clk_en          <= 1'b0;
      o_timer2_clk_en          <= 1'b0;
      o_timer3_clk_en          <= 1'b0;
      o_spi_clk_en             <= 1'b0;
      o_serial_tx_clk_en       <= 1'b0;
      o_serial_rx_clk_en       <= 1'b0;
      o_pwm_clk_en             <= '0;
      o_converter_pwr          <= 1'b0;
      o_set_mask_i             <= 1'b0;
      o_set_mask_x             <= 1'b0;
      o_service_nmi            <= 1'b0;
      o_resume                 <= 1'b0;
      o_oscillator_wait_select <= WAIT_SEL_RST;
      o_state                  <= 3'h0;
    end else begin
      o_stack_req     <= (state_d == ST_STACK);
      o_bus_rd        <= idling;
      o_bus_addr      <= idling ? i_flags_addr : o_bus_addr;
      // cpu held in idle and stop; state untouched
      o_cpu_clk_en    <= !idling && !stopped && !dly_busy;
      o_osc_en        <= (state_d != ST_STOP);
      o_timer1_clk_en    <= !stopped && !t1_halt;
      o_timer2_clk_en    <= !stopped && !t2_halt;
      o_timer3_clk_en    <= !stopped && !t3_halt;
      o_spi_clk_en       <= !stopped && i_spi_on;
      o_serial_tx_clk_en <= !stopped && i_serial_tx_on;
      o_serial_rx_clk_en <= !stopped && i_serial_rx_on;
      o_pwm_clk_en       <= stopped ? '0 : i_pwm_channel_on;
      // converter ignores idle; its own bit, forced off in stop and oscillator wait
      o_converter_pwr    <= i_converter_power_on && !stopped;
      o_set_mask_i    <= entering;
      o_set_mask_x    <= entering && nmi_wake_d;
      o_service_nmi   <= entering && nmi_wake_d;
      o_resume        <= (state_q != ST_RUN) && (state_d == ST_RUN);
      o_oscillator_wait_select <= wait_sel_q;
      o_state         <= 3'(state_d);
    end
  end

endmodule : lpm_ctrl

// ==== dv/lpm_ctrl_assertions.sv ====
// port checker for the low-power wait/stop controller
// assumes default widths and the state encoding of lpm_state_t
`timescale 1ns/10ps
// ==========================================================
// checker module
module lpm_ctrl_checker
  import lpm_pkg::*;
(
  input wire logic        I_REF_CLK,
  input wire logic        I_NRST,
  input wire logic        i_stop_opcode,
  input wire logic        i_flag_s,
  input wire logic        i_flag_i,
  input wire logic        i_nmi_n,
  input wire logic        i_edge_irq_pending,
  input wire logic        i_warm_reset,
  input wire logic        i_watchdog_off,
  input wire logic [15:0] i_flags_addr,
  input wire logic [3:0]  i_pwm_channel_on,
  input wire logic        o_bus_rd,
  input wire logic [15:0] o_bus_addr,
  input wire logic        o_cpu_clk_en,
  input wire logic        o_osc_en,
  input wire logic        o_timer1_clk_en,
  input wire logic [3:0]  o_pwm_clk_en,
  input wire logic        o_set_mask_i,
  input wire logic        o_set_mask_x,
  input wire logic        o_oscillator_wait_select,
  input wire logic [2:0]  o_state
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  // state decodes; opcodes only count while the cpu really runs
  wire idle = o_state == ST_IDLE;
  wire stop = o_state == ST_STOP;
  wire take = o_state == ST_RUN && o_cpu_clk_en && i_stop_opcode && !i_warm_reset;

  idle_clocks_a: assert property (idle |-> o_osc_en && !o_cpu_clk_en)
    else $error("idle clock gating wrong");
  flag_read_a: assert property (idle |-> o_bus_rd && o_bus_addr == i_flags_addr)
    else $error("idle read cycle wrong");
  stop_clocks_a: assert property (stop |-> !o_osc_en && !o_cpu_clk_en && !o_timer1_clk_en)
    else $error("clock alive in stop");
  stop_nop_a: assert property (take && i_flag_s |=> !stop)
    else $error("stop taken with halt disable set");
  stop_enter_a: assert property (take && !i_flag_s |=> stop)
    else $error("stop not taken");
  irq_masked_a: assert property (stop && i_flag_i && i_nmi_n && !i_edge_irq_pending && !i_warm_reset |=> stop)
    else $error("masked wake from stop");
  nmi_wake_a: assert property (stop && !i_nmi_n |-> ##[1:2] !stop)
    else $error("nmi line did not wake stop");
  timer_halt_a: assert property (idle && $past(idle) && i_flag_i && i_watchdog_off && $past(i_flag_i) && $past(i_watchdog_off) |-> !o_timer1_clk_en)
    else $error("main timer not halted");
  timer_run_a: assert property (idle && $past(idle) && !i_flag_i && !$past(i_flag_i) |-> o_timer1_clk_en)
    else $error("main timer halted");
  pwm_gate_a: assert property ((o_pwm_clk_en & ~(i_pwm_channel_on | $past(i_pwm_channel_on))) == 4'h0)
    else $error("pwm clock without enable");
  mask_pair_a: assert property (o_set_mask_x |-> o_set_mask_i)
    else $error("nmi service without mask set");
  warm_select_a: assert property (i_warm_reset |=> ##1 o_oscillator_wait_select)
    else $error("warm reset kept select clear");
  warm_nodelay_a: assert property (i_warm_reset && o_state == ST_RUN |=> (o_state != ST_OSC_WAIT) [*3])
    else $error("delay after warm reset");
endmodule : lpm_ctrl_checker

bind lpm_ctrl lpm_ctrl_checker i_chk (.*);

// ==== dv/lpm_far_side.sv ====
// model of the external interrupt lines feeding the controller
// assumes pulled-up lines, so a released line reads high once the device is back in run
`timescale 1ns/10ps
// ==========================================================
// far side model
module lpm_far_side (
  input  wire logic       I_REF_CLK,
  input  wire logic       i_irq_req,
  input  wire logic       i_nmi_req,
  input  wire logic [2:0] i_state,
  output logic            o_irq_n,
  output logic            o_nmi_n
);
  initial {o_irq_n, o_nmi_n} = 2'h3;
  // a low level is held until the device is back in run, never a glitch
  always @(posedge I_REF_CLK) begin
    o_irq_n <= i_irq_req ? 1'b0 : (i_state == 3'h0 ? 1'b1 : o_irq_n);
    o_nmi_n <= i_nmi_req ? 1'b0 : (i_state == 3'h0 ? 1'b1 : o_nmi_n);
  end
endmodule : lpm_far_side

// ==== dv/low_power_wait_stop_control_tb_top.sv ====
// self-checking bench for the low-power wait/stop controller
// assumes a 16-cycle oscillator delay and the far side model
`timescale 1ns/10ps
// ==========================================================
// bench top
module low_power_wait_stop_control_tb_top
  import lpm_pkg::*;
;
  localparam int OW = 16;
  logic I_REF_CLK, I_NRST, i_idle_opcode, i_stop_opcode, i_stack_done;
  logic i_flag_i, i_flag_x, i_flag_s, i_int_pending, i_edge_irq_pending;
  logic i_irq_n, i_nmi_n, i_warm_reset, i_watchdog_off, i_timer2_halt_ctrl;
  logic i_timer3_halt_ctrl, i_spi_on, i_serial_tx_on, i_serial_rx_on;
  logic i_converter_power_on, i_wait_sel_wr, i_wait_sel_val, irq_req, nmi_req;
  logic [15:0] i_flags_addr, o_bus_addr;
  logic [3:0]  i_pwm_channel_on, o_pwm_clk_en;
  logic [2:0]  o_state;
  logic o_stack_req, o_bus_rd, o_cpu_clk_en, o_osc_en, o_timer1_clk_en;
  logic o_timer2_clk_en, o_timer3_clk_en, o_spi_clk_en, o_serial_tx_clk_en;
  logic o_serial_rx_clk_en, o_converter_pwr, o_set_mask_i, o_set_mask_x;
  logic o_service_nmi, o_resume, o_oscillator_wait_select;
  int failures, checks_done, n_ow, n_mi, n_mx, n_sv;

  lpm_ctrl #(.OSC_WAIT(OW)) i_dut (.*);
  lpm_far_side i_far (.I_REF_CLK(I_REF_CLK), .i_irq_req(irq_req),
    .i_nmi_req(nmi_req), .i_state(o_state), .o_irq_n(i_irq_n),
    .o_nmi_n(i_nmi_n));

  initial begin
    I_REF_CLK = 1'b0;
    forever #2.5 I_REF_CLK = ~I_REF_CLK;
  end
  // pulse and delay counters, cleared by the sequence between scenarios
  always @(posedge I_REF_CLK) begin
    n_ow += (o_state === ST_OSC_WAIT);
    n_mi += (o_set_mask_i === 1'b1);
    n_mx += (o_set_mask_x === 1'b1);
    n_sv += (o_service_nmi === 1'b1);
  end

  task automatic wrap_up;
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick;
    @(posedge I_REF_CLK);
    #1;
  endtask : tick
  // bounded wait; run only counts once the cpu clock is back
  task automatic wait_st(input logic [2:0] st);
    int n;
    for (n = 0; n < 300; n++) begin
      if (o_state === st && (st != 3'h0 || o_cpu_clk_en === 1'b1)) return;
      tick;
    end
    failures++;
    wrap_up;
  endtask : wait_st
  task automatic op(input bit stop);
    {n_ow, n_mi, n_mx, n_sv} = '0;
    if (stop) i_stop_opcode = 1'b1;
    else i_idle_opcode = 1'b1;
    tick;
    {i_stop_opcode, i_idle_opcode} = 2'h0;
  endtask : op

  // main sequence; expected gates come from integer arithmetic
  initial begin
    int ti;
    {I_NRST, i_idle_opcode, i_stop_opcode, i_stack_done, i_flag_s} = '0;
    {i_int_pending, i_edge_irq_pending, i_warm_reset, i_watchdog_off} = '0;
    {i_timer2_halt_ctrl, i_timer3_halt_ctrl, i_spi_on, irq_req} = '0;
    {i_serial_tx_on, i_serial_rx_on, i_converter_power_on, nmi_req} = '0;
    {i_wait_sel_wr, i_wait_sel_val, i_pwm_channel_on} = '0;
    {i_flag_i, i_flag_x, i_flags_addr} = {2'h3, 16'h0100};
    {failures, checks_done, n_ow} = '0;
    void'($urandom(32'hda594c60));
    repeat (20) @(posedge I_REF_CLK);
    #1 I_NRST = 1'b1;
    wait_st(ST_RUN);
    check(n_ow >= OW, 1);
    check(o_oscillator_wait_select, 1);
    repeat (4) begin
      {i_spi_on, i_serial_tx_on, i_serial_rx_on, i_converter_power_on,
       i_pwm_channel_on} = 8'($urandom);
      tick;
      tick;
      check({o_spi_clk_en, o_serial_tx_clk_en, o_serial_rx_clk_en},
        {i_spi_on, i_serial_tx_on, i_serial_rx_on});
      check(o_pwm_clk_en, i_pwm_channel_on);
      check(o_converter_pwr, i_converter_power_on);
    end
    for (int k = 0; k < 4; k++) begin
      {i_watchdog_off, i_flag_i} = 2'(k);
      {i_timer2_halt_ctrl, i_timer3_halt_ctrl} = 2'($urandom);
      i_flags_addr = 16'($urandom);
      op(0);
      wait_st(ST_STACK);
      check(o_stack_req, 1);
      i_stack_done = 1'b1;
      tick;
      i_stack_done = 1'b0;
      wait_st(ST_IDLE);
      tick;
      ti = (k == 3) ? 0 : 1;
      check({o_bus_rd, o_osc_en, o_cpu_clk_en}, 3'b110);
      check(o_bus_addr, i_flags_addr);
      check(o_timer1_clk_en, ti);
      check({o_timer2_clk_en, o_timer3_clk_en},
        2'(~{i_timer2_halt_ctrl, i_timer3_halt_ctrl}));
      check(o_converter_pwr, i_converter_power_on);
      i_int_pending = 1'b1;
      wait_st(ST_RUN);
      i_int_pending = 1'b0;
      check(n_mi, 1);
    end
    i_flag_s = 1'b1;
    op(1);
    repeat (3) tick;
    check({o_state, o_osc_en}, 4'h1);
    {i_flag_s, i_flag_i} = 2'h1;
    op(1);
    wait_st(ST_STOP);
    check({o_osc_en, o_cpu_clk_en, o_pwm_clk_en}, 6'h0);
    irq_req = 1'b1;
    tick;
    irq_req = 1'b0;
    repeat (10) tick;
    check(o_state, ST_STOP);
    nmi_req = 1'b1;
    tick;
    nmi_req = 1'b0;
    wait_st(ST_RUN);
    check(n_ow >= OW, 1);
    check(n_mi + n_mx + n_sv, 0);
    {i_wait_sel_wr, i_wait_sel_val, i_flag_i} = 3'h4;
    tick;
    i_wait_sel_wr = 1'b0;
    tick;
    check(o_oscillator_wait_select, 0);
    for (int w = 0; w < 3; w++) begin
      i_flag_x = (w != 2);
      op(1);
      wait_st(ST_STOP);
      if (w == 0) irq_req = 1'b1;
      if (w == 1) i_edge_irq_pending = 1'b1;
      if (w == 2) nmi_req = 1'b1;
      tick;
      irq_req = 1'b0;
      nmi_req = 1'b0;
      wait_st(ST_RUN);
      i_edge_irq_pending = 1'b0;
      check(n_ow, 0);
      check(n_mi, 1);
      check(n_mx, (w == 2) ? 1 : 0);
      check(n_sv, (w == 2) ? 1 : 0);
    end
    {n_ow, i_warm_reset} = '1;
    n_ow = 0;
    tick;
    i_warm_reset = 1'b0;
    tick;
    check(o_oscillator_wait_select, 1);
    wait_st(ST_RUN);
    check(n_ow, 0);
    wrap_up;
  end
endmodule : low_power_wait_stop_control_tb_top
